// File: logic/odv_defs.vh
// constants of the off-delay and channel 1 voltage register bank
// assumes mclk at 250 MHz and an 8-bit register access port
`ifndef ODV_DEFS_VH
`define ODV_DEFS_VH
`define ODV_ADDR_W 8
`define ODV_DLY56_OFS 8'h0A
`define ODV_DLY7_OFS 8'h0B
`define ODV_VOUT1_OFS 8'h0C
`define ODV_CFG_OFS 8'h23
`define ODV_CH5_LSB 0
`define ODV_CH6_LSB 4
`define ODV_CH7_LSB 0
`define ODV_VCODE_LSB 0
`define ODV_EXTEND_BIT 2
`define ODV_REDUCE_BIT 3
`define ODV_DLY56_MASK 8'h77
`define ODV_DLY7_MASK 8'h07
`define ODV_VOUT1_MASK 8'h1F
`define ODV_CFG_MASK 8'h0C
`define ODV_CFG_RESET 8'h00
`define ODV_STEP_MS 4
`define ODV_STEP_EXT_MS 16
`define ODV_CLK_KHZ 18'h3D090
`define ODV_MV_BASE 11'h4B0
`define ODV_MV_BASE_RED 11'h456
`define ODV_MV_STEP 11'h00A
`endif

// File: logic/odv_delay_timer.v
// one channel power-down delay timer
// assumes a single clock and a millisecond enable pulse from the parent
`timescale 1ns/1ps
`default_nettype none
`include "odv_defs.vh"
module odv_delay_timer
(
	input wire mclk,
	input wire reset,
	input wire msTick,
	input wire start,
	input wire [2:0] code,
	input wire extend,
	output reg done_r
);
reg [6:0] msLeft_r;
reg busy_r;
// ----------------------------------------
// delay count
// ----------------------------------------
// scaled by four, or by sixteen when extend is set
function [6:0] delayMs;
	input [2:0] c;
	input ext;
	begin
		if (ext)
			delayMs = {c, 4'h0};
		else
			delayMs = {2'h0, c, 2'h0};
	end
endfunction
always @(posedge mclk)
begin
	if (reset)
	begin
		msLeft_r <= 7'h00;
		busy_r <= 1'b0;
		done_r <= 1'b0;
	end
	else
	begin
		done_r <= 1'b0;
		if (start)
		begin
			if (delayMs(code, extend) == 7'h00)
			begin
				done_r <= 1'b1;
				busy_r <= 1'b0;
			end
			else
			begin
				msLeft_r <= delayMs(code, extend);
				busy_r <= 1'b1;
			end
		end
		else if (busy_r && msTick)
		begin
			if (msLeft_r == 7'h01)
			begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end
			msLeft_r <= msLeft_r - 7'h01;
		end
	end
end
endmodule
`default_nettype wire

// File: logic/odv_regs.v
// off-delay and channel 1 voltage register bank
// assumes a host register port on mclk and fuse values held stable in reset
// Behaviour
// - register 0x0A: bits 6:4 channel 6 delay, bits 2:0 channel 5 delay
// - register 0x0B: bits 2:0 channel 7 delay, other bits unused
// - extend clear: delay is code times 4 ms, 0 to 28 ms
// - extend set: delay is code times 16 ms, up to 112 ms
// - range extend comes from bit 2 of register 0x23
// - delay fields load fuse defaults at reset, register 0x23 clears to 0; then host read/write
// - register 0x0C: bits 4:0 channel 1 voltage code, read/write
// - reduce clear: 1.20 V at code 0, minus 10 mV per step
// - reduce set: 1.11 V at code 0, minus 10 mV per step
// - voltage reduce comes from bit 3 of register 0x23
`timescale 1ns/1ps
`default_nettype none
`include "odv_defs.vh"
module odv_regs
(
	input wire mclk,
	input wire reset,
	input wire [7:0] fuseDly56,
	input wire [7:0] fuseDly7,
	input wire [7:0] fuseVout1,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regAddr,
	input wire [7:0] regWdata,
	output reg [7:0] regRdata_r,
	input wire [2:0] offStart,
	output wire [2:0] offDone,
	output reg [10:0] ch1VoltageMv_r,
	output wire offDelayRangeExtend,
	output wire ch1VoltageReduce
);

localparam [17:0] MS_CYCLES = `ODV_CLK_KHZ;
reg [7:0] dly56_r;
reg [7:0] dly7_r;
reg [7:0] vout1_r;
reg [7:0] cfg_r;
reg [17:0] msCnt_r;
reg msTick_r;
wire [2:0] ch5OffDelayCode;
wire [2:0] ch6OffDelayCode;
wire [2:0] ch7OffDelayCode;
wire [4:0] ch1VoltageCode;
wire hitDly56;
wire hitDly7;
wire hitVout1;
wire hitCfg;

assign ch5OffDelayCode = dly56_r[`ODV_CH5_LSB +: 3];
assign ch6OffDelayCode = dly56_r[`ODV_CH6_LSB +: 3];
assign ch7OffDelayCode = dly7_r[`ODV_CH7_LSB +: 3];
assign ch1VoltageCode = vout1_r[`ODV_VCODE_LSB +: 5];
assign hitDly56 = regWrite && (regAddr == `ODV_DLY56_OFS);
assign hitDly7 = regWrite && (regAddr == `ODV_DLY7_OFS);
assign hitVout1 = regWrite && (regAddr == `ODV_VOUT1_OFS);
assign hitCfg = regWrite && (regAddr == `ODV_CFG_OFS);
assign offDelayRangeExtend = cfg_r[`ODV_EXTEND_BIT];
assign ch1VoltageReduce = cfg_r[`ODV_REDUCE_BIT];

// ----------------------------------------
// field masks
// ----------------------------------------
// unused bits dropped
function [7:0] fieldMask;
	input [7:0] addr;
	begin
		case (addr)
			`ODV_DLY56_OFS: fieldMask = `ODV_DLY56_MASK;
			`ODV_DLY7_OFS: fieldMask = `ODV_DLY7_MASK;
			`ODV_VOUT1_OFS: fieldMask = `ODV_VOUT1_MASK;
			`ODV_CFG_OFS: fieldMask = `ODV_CFG_MASK;
			default: fieldMask = 8'h00;
		endcase
	end
endfunction

// ----------------------------------------
// register writes
// ----------------------------------------
// channel 5/6 delays
always @(posedge mclk)
begin
	if (reset)
		dly56_r <= fuseDly56 & fieldMask(`ODV_DLY56_OFS);
	else if (hitDly56)
		dly56_r <= regWdata & fieldMask(`ODV_DLY56_OFS);
end

always @(posedge mclk)
begin
	if (reset)
		dly7_r <= fuseDly7 & fieldMask(`ODV_DLY7_OFS);
	else if (hitDly7)
		dly7_r <= regWdata & fieldMask(`ODV_DLY7_OFS);
end

always @(posedge mclk)
begin
	if (reset)
		vout1_r <= fuseVout1 & fieldMask(`ODV_VOUT1_OFS);
	else if (hitVout1)
		vout1_r <= regWdata & fieldMask(`ODV_VOUT1_OFS);
end

always @(posedge mclk)
begin
	if (reset)
		cfg_r <= `ODV_CFG_RESET;
	else if (hitCfg)
		cfg_r <= regWdata & fieldMask(`ODV_CFG_OFS);
end

// ----------------------------------------
// read data
// ----------------------------------------
always @(posedge mclk)
begin
	if (reset)
		regRdata_r <= 8'h00;
	else if (regRead)
	begin
		case (regAddr)
			`ODV_DLY56_OFS: regRdata_r <= dly56_r;
			`ODV_DLY7_OFS: regRdata_r <= dly7_r;
			`ODV_VOUT1_OFS: regRdata_r <= vout1_r;
			`ODV_CFG_OFS: regRdata_r <= cfg_r;
			default: regRdata_r <= 8'h00;
		endcase
	end
end
// ----------------------------------------
// channel 1 voltage
// ----------------------------------------
// code to millivolts
function [10:0] millivolts;
	input [4:0] code;
	input reduce;
	begin
		if (reduce)
			millivolts = `ODV_MV_BASE_RED - `ODV_MV_STEP * {6'h00, code};
		else
			millivolts = `ODV_MV_BASE - `ODV_MV_STEP * {6'h00, code};
	end
endfunction
always @(posedge mclk)
begin
	if (reset)
		ch1VoltageMv_r <= 11'h000;
	else
		ch1VoltageMv_r <= millivolts(ch1VoltageCode, ch1VoltageReduce);
end

// ----------------------------------------
// millisecond tick
// ----------------------------------------
always @(posedge mclk)
begin
	if (reset)
	begin
		msCnt_r <= 18'h00000;
		msTick_r <= 1'b0;
	end
	else if (msCnt_r == MS_CYCLES - 18'h00001)
	begin
		msCnt_r <= 18'h00000;
		msTick_r <= 1'b1;
	end
	else
	begin
		msCnt_r <= msCnt_r + 18'h00001;
		msTick_r <= 1'b0;
	end
end

// ----------------------------------------
// delay timers
// ----------------------------------------
odv_delay_timer ch5Timer
(
	.mclk(mclk),
	.reset(reset),
	.msTick(msTick_r),
	.start(offStart[0]),
	.code(ch5OffDelayCode),
	.extend(offDelayRangeExtend),
	.done_r(offDone[0])
);
odv_delay_timer ch6Timer
(
	.mclk(mclk),
	.reset(reset),
	.msTick(msTick_r),
	.start(offStart[1]),
	.code(ch6OffDelayCode),
	.extend(offDelayRangeExtend),
	.done_r(offDone[1])
);
odv_delay_timer ch7Timer
(
	.mclk(mclk),
	.reset(reset),
	.msTick(msTick_r),
	.start(offStart[2]),
	.code(ch7OffDelayCode),
	.extend(offDelayRangeExtend),
	.done_r(offDone[2])
);
endmodule
`default_nettype wire

// File: dv/odv_regs_sva.sv
// port checker for odv_regs
// assumes one mclk domain, bound below
`timescale 1ns/1ps
`default_nettype none
module odv_regs_sva
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata_r,
	input wire logic [10:0] ch1VoltageMv_r,
	input wire logic offDelayRangeExtend,
	input wire logic ch1VoltageReduce
);
	// ----
	// checks
	// ----
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_extend_copy: assert property (regWrite && regAddr == 8'h23 |=> offDelayRangeExtend == $past(regWdata[2]))
		else $error("bad extend");
	a_reduce_copy: assert property (regWrite && regAddr == 8'h23 |=> ch1VoltageReduce == $past(regWdata[3]))
		else $error("bad reduce");
	a_cfg_hold: assert property (!(regWrite && regAddr == 8'h23) |=> $stable({offDelayRangeExtend, ch1VoltageReduce}))
		else $error("cfg moved");
	a_mv_table: assert property (regWrite && regAddr == 8'h0C ##1 !(regWrite && regAddr == 8'h0C) |=>
		ch1VoltageMv_r == ($past(ch1VoltageReduce) ? 11'd1110 : 11'd1200) - 11'd10 * $past(regWdata[4:0], 2))
		else $error("bad millivolts");
	a_dly56_back: assert property (regWrite && regAddr == 8'h0A ##1 regRead && regAddr == 8'h0A |=>
		regRdata_r == ($past(regWdata, 2) & 8'h77))
		else $error("bad 0A read");
	a_dly7_back: assert property (regWrite && regAddr == 8'h0B ##1 regRead && regAddr == 8'h0B |=>
		regRdata_r == ($past(regWdata, 2) & 8'h07))
		else $error("bad 0B read");
	a_vout_back: assert property (regWrite && regAddr == 8'h0C ##1 regRead && regAddr == 8'h0C |=>
		regRdata_r == ($past(regWdata, 2) & 8'h1F))
		else $error("bad 0C read");
	a_unmapped_zero: assert property (regRead && regAddr == 8'h0D |=> regRdata_r == 8'h00)
		else $error("bad 0D read");
endmodule
bind odv_regs odv_regs_sva odv_regs_sva_inst (.mclk, .reset, .regWrite, .regRead, .regAddr, .regWdata,
	.regRdata_r, .ch1VoltageMv_r, .offDelayRangeExtend, .ch1VoltageReduce);
`default_nettype wire

// File: dv/odv_regs_test.sv
// self-checking bench for odv_regs
// assumes the checker binds itself
`timescale 1ns/1ps
`default_nettype none
module odv_regs_test;
	logic mclk = 1'b0;
	logic reset, regWrite, regRead;
	logic [7:0] fuseDly56, fuseDly7, fuseVout1, regAddr, regWdata, regRdata_r, cfg, a, d;
	logic [2:0] offStart, offDone;
	logic [10:0] ch1VoltageMv_r;
	logic offDelayRangeExtend, ch1VoltageReduce;
	logic [31:0] seed;
	logic [4:0] code;
	int nMismatch, checksDone, i, k;
	odv_regs odv_regs_inst (.mclk, .reset, .fuseDly56, .fuseDly7, .fuseVout1, .regWrite, .regRead, .regAddr,
		.regWdata, .regRdata_r, .offStart, .offDone, .ch1VoltageMv_r, .offDelayRangeExtend, .ch1VoltageReduce);
	// ----
	// helpers
	// ----
	initial
	begin
		forever #2 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] maskOf(input logic [7:0] x);
		return x == 8'h0A ? 8'h77 : x == 8'h0B ? 8'h07 : x == 8'h0C ? 8'h1F : x == 8'h23 ? 8'h0C : 8'h00;
	endfunction
	function automatic logic [10:0] mvOf(input logic [4:0] c, input logic r);
		return (r ? 11'd1110 : 11'd1200) - 11'd10 * c;
	endfunction
	task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		checksDone++;
		if (g !== e)
		begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] x, input logic [7:0] y);
		regWrite = 1'b1;
		regAddr = x;
		regWdata = y;
		@(negedge mclk);
		regWrite = 1'b0;
	endtask
	task automatic rd(input logic [7:0] x, input logic [7:0] e);
		regRead = 1'b1;
		regAddr = x;
		@(negedge mclk);
		regRead = 1'b0;
		chk("read data", {3'h0, e}, {3'h0, regRdata_r});
	endtask
	task automatic wrapUp;
		$display("mismatches %0d checks %0d", nMismatch, checksDone);
		if (nMismatch == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		{regWrite, regRead, offStart, regAddr, regWdata, cfg} = '0;
		reset = 1'b1;
		nMismatch = 0;
		checksDone = 0;
		seed = 32'h08CB;
		repeat (40) seed = lfsr(seed);
		{fuseDly56, fuseDly7, fuseVout1} = seed[23:0];
		repeat (4) @(negedge mclk);
		reset = 1'b0;
		rd(8'h0A, fuseDly56 & 8'h77);
		@(negedge mclk);
		rd(8'h0B, fuseDly7 & 8'h07);
		@(negedge mclk);
		rd(8'h0C, fuseVout1 & 8'h1F);
		code = fuseVout1[4:0];
		for (i = 0; i < 60; i++)
		begin
			seed = lfsr(seed);
			a = seed[2] ? 8'h23 : 8'h0A + {6'h0, seed[1:0]};
			d = seed[15:8];
			wr(a, d);
			if (a == 8'h0C)
				code = d[4:0];
			if (a == 8'h23)
				cfg = d & 8'h0C;
			rd(a, d & maskOf(a));
			@(negedge mclk);
			chk("millivolts", mvOf(code, cfg[3]), ch1VoltageMv_r);
			chk("config", {9'h0, cfg[3:2]}, {9'h0, ch1VoltageReduce, offDelayRangeExtend});
		end
		for (i = 0; i < 2; i++)
		begin
			@(negedge mclk);
			wr(8'h23, {5'h0, i[0], 2'h0});
			@(negedge mclk);
			wr(8'h0A, 8'h88);
			@(negedge mclk);
			wr(8'h0B, 8'hF8);
			offStart = 3'h7;
			@(negedge mclk);
			offStart = 3'h0;
			for (k = 0; k < 3 && offDone !== 3'h7; k++)
				@(negedge mclk);
			chk("done", 11'h7, {8'h0, offDone});
			@(negedge mclk);
			chk("done", 11'h0, {8'h0, offDone});
			seed = lfsr(seed);
			wr(8'h0A, seed[15:8] | 8'h11);
			@(negedge mclk);
			wr(8'h0B, {5'h0, seed[2:0] | 3'h1});
			offStart = 3'h7;
			@(negedge mclk);
			offStart = 3'h0;
			for (k = 0; k < 300; k++)
			begin
				chk("early done", 11'h0, {8'h0, offDone});
				@(negedge mclk);
			end
		end
		wrapUp;
	end
endmodule
`default_nettype wire
